// file: hw/port_pins.sv
`timescale 1ns/10ps
`include "port_pins_params.svh"
// Notes on behaviour
// - first port: eight open-drain pins, pull low only, no pull-up
// - writing one to a latch bit releases that pin for input
// - external data access puts address byte, then data byte, on first port
// - during address phase and write data phase ones are driven high actively; read data phase releases all pins
// - second port: eight input-only pins, never driven
// - second port pins are analog inputs after reset
// - writing zero to a second port bit makes it digital input
// - converter channel chosen by converter control field, not port logic
// - second pin of second port triggers counter capture or reload
// - same pin gives counter count direction
module port_pins
  import port_pins_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // first port latch
  input  wire logic       od_latch_wr,
  input  wire port_byte_t od_latch_wdata,
  output logic [7:0]      od_port_read,
  // external data access request
  input  wire logic       xmem_start,
  input  wire logic       xmem_write,
  input  wire port_byte_t ext_addr_low,
  input  wire port_byte_t xmem_wdata,
  output logic [7:0]      xmem_rdata,
  output logic            xmem_done,
  output logic            addr_phase,
  // first port pins
  input  wire port_byte_t od_port_in,
  output logic [7:0]      od_port_out,
  output logic [7:0]      od_port_oe,
  // second port
  input  wire logic       in_latch_wr,
  input  wire port_byte_t in_latch_wdata,
  input  wire port_byte_t input_port_in,
  output logic [7:0]      input_port_read,
  output logic [7:0]      analog_mode,
  // converter channel from converter_control_two
  input  wire logic [2:0] converter_chan_sel,
  output logic [2:0]      analog_input_channel,
  // counter two
  output logic            counter2_trigger_dir_input
);
  input_cfg_if cfg ();
  bus_state_t  state_reg;
  port_byte_t  od_latch_reg;
  port_byte_t  xaddr_reg;
  port_byte_t  xdata_reg;
  logic        xwr_reg;

  input_port u_input (
    .core_clk    (core_clk),
    .nrst        (nrst),
    .latch_wr    (in_latch_wr),
    .latch_wdata (in_latch_wdata),
    .pin_in      (input_port_in),
    .cfg         (cfg)
  );

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      od_latch_reg <= `OD_LATCH_RESET;
    end else if (od_latch_wr) begin
      od_latch_reg <= od_latch_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= BUS_IDLE;
      xaddr_reg <= 8'h00;
      xdata_reg <= 8'h00;
      xwr_reg   <= 1'b0;
    end else begin
      case (state_reg)
        BUS_IDLE: begin
          if (xmem_start) begin
            state_reg <= BUS_ADDR;
            xaddr_reg <= ext_addr_low;
            xdata_reg <= xmem_wdata;
            xwr_reg   <= xmem_write;
          end
        end
        BUS_ADDR: state_reg <= BUS_DATA;
        BUS_DATA: state_reg <= BUS_IDLE;
        default:  state_reg <= BUS_IDLE;
      endcase
    end
  end

  // pin drive
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      od_port_out <= 8'h00;
      od_port_oe  <= 8'h00;
    end else if (xmem_start && state_reg == BUS_IDLE) begin
      od_port_out <= ext_addr_low;
      od_port_oe  <= 8'hff;
    end else if (state_reg == BUS_ADDR) begin
      od_port_out <= xdata_reg;
      od_port_oe  <= xwr_reg ? 8'hff : 8'h00;
    end else begin
      od_port_out <= 8'h00;
      od_port_oe  <= ~(od_latch_wr ? od_latch_wdata : od_latch_reg);
    end
  end

  // status and reads
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      xmem_done       <= 1'b0;
      xmem_rdata      <= 8'h00;
      addr_phase      <= 1'b0;
      od_port_read    <= 8'h00;
      input_port_read <= 8'h00;
      analog_mode     <= `IN_LATCH_RESET;
    end else begin
      xmem_done  <= state_reg == BUS_DATA;
      addr_phase <= xmem_start && state_reg == BUS_IDLE;
      if (state_reg == BUS_DATA && !xwr_reg) begin
        xmem_rdata <= od_port_in;
      end
      od_port_read    <= od_port_in;
      input_port_read <= cfg.digital_value;
      analog_mode     <= cfg.analog_mode;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      analog_input_channel       <= 3'h0;
      counter2_trigger_dir_input <= 1'b0;
    end else begin
      analog_input_channel       <= converter_chan_sel;
      counter2_trigger_dir_input <= cfg.digital_value[`TRIG_BIT];
    end
  end

  sequence s_addr_phase;
    state_reg == BUS_ADDR && od_port_oe == 8'hff;
  endsequence
  // next start may follow at once, so only the first idle cycle is judged
  sequence s_back_idle;
    state_reg == BUS_IDLE && od_port_out == 8'h00 && od_port_oe == ~od_latch_reg;
  endsequence

  a_bus_addr_first: assert property (@(posedge core_clk) disable iff (!nrst)
    (xmem_start && state_reg == BUS_IDLE) |=> s_addr_phase ##0 od_port_out == $past(ext_addr_low))
    else $error("address byte not driven first");
  a_bus_ends_od: assert property (@(posedge core_clk) disable iff (!nrst)
    state_reg == BUS_DATA |=> s_back_idle)
    else $error("port did not return to open drain");
  a_od_low_only: assert property (@(posedge core_clk) disable iff (!nrst)
    state_reg == BUS_IDLE && !$past(xmem_start) |-> od_port_out == 8'h00)
    else $error("open drain drove high");
  a_one_floats: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_reg == BUS_IDLE && !xmem_start && od_latch_wr) |=>
      od_port_oe == ~$past(od_latch_wdata))
    else $error("written one did not release pin");
  a_trig_follows: assert property (@(posedge core_clk) disable iff (!nrst)
    ##2 counter2_trigger_dir_input == ($past(input_port_in[1], 2) & ~$past(analog_mode[1])))
    else $error("counter input does not follow pin");
endmodule

// file: pkg/port_pins_params.svh
`ifndef PORT_PINS_PARAMS_SVH
`define PORT_PINS_PARAMS_SVH
`define PORT_WIDTH         8
`define OD_LATCH_RESET     8'hff
`define IN_LATCH_RESET     8'hff
`define TRIG_BIT           1
`define CHAN_SEL_WIDTH     3
`endif

// file: pkg/port_pins_pkg.sv
package port_pins_pkg;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_ADDR = 3'b010,
    BUS_DATA = 3'b100
  } bus_state_t;
  typedef logic [7:0] port_byte_t;
endpackage

// file: pkg/input_cfg_if.sv
`timescale 1ns/10ps
interface input_cfg_if;
  logic [7:0] analog_mode;
  logic [7:0] digital_value;
  modport owner (output analog_mode, output digital_value);
  modport user  (input analog_mode, input digital_value);
endinterface

// file: hw/input_port.sv
`timescale 1ns/10ps
`include "port_pins_params.svh"
module input_port
  import port_pins_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // latch write
  input  wire logic       latch_wr,
  input  wire port_byte_t latch_wdata,
  // pins
  input  wire port_byte_t pin_in,
  input_cfg_if.owner      cfg
);
  port_byte_t mode_reg;
  port_byte_t value_reg;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= `IN_LATCH_RESET;
    end else if (latch_wr) begin
      mode_reg <= latch_wdata;
    end
  end

  // analog pins read as zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      value_reg <= 8'h00;
    end else begin
      value_reg <= pin_in & ~mode_reg;
    end
  end

  assign cfg.analog_mode   = mode_reg;
  assign cfg.digital_value = value_reg;

  a_reset_analog: assert property (@(posedge core_clk) $rose(nrst) |-> mode_reg == 8'hff)
    else $error("input port not analog after reset");
  a_zero_digital: assert property (@(posedge core_clk) disable iff (!nrst)
    latch_wr |=> mode_reg == $past(latch_wdata))
    else $error("mode latch did not take write");
endmodule

// file: verification/ext_mem_model.sv
`timescale 1ns/10ps
module ext_mem_model
  import port_pins_pkg::*;
(
  // clock
  input  wire logic       core_clk,
  // pin side
  input  wire logic       addr_phase,
  input  wire port_byte_t pin_out,
  input  wire port_byte_t pin_oe,
  input  wire port_byte_t board_level,
  output port_byte_t      pin_in
);
  port_byte_t mem [256];
  port_byte_t addr_reg;
  logic       data_reg;
  port_byte_t ext_val;
  always_ff @(posedge core_clk) begin
    data_reg <= addr_phase;
    if (addr_phase)
      addr_reg <= pin_out;
    if (data_reg && pin_oe == 8'hff)
      mem[addr_reg] <= pin_out;
  end
  // released bits float to the board level, except in the data phase, where they take the memory byte
  assign ext_val = data_reg ? mem[addr_reg] : board_level;
  assign pin_in  = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule

// file: verification/port_pins_tb_top.sv
`timescale 1ns/10ps
module port_pins_tb_top
  import port_pins_pkg::*;
;
  logic       core_clk = 1'b0;
  logic       nrst = 1'b0;
  logic       od_latch_wr = 1'b0, xmem_start = 1'b0, xmem_write = 1'b0, in_latch_wr = 1'b0;
  port_byte_t od_latch_wdata = 8'h00, ext_addr_low = 8'h00, xmem_wdata = 8'h00;
  port_byte_t in_latch_wdata = 8'h00, input_port_in = 8'h00, board_level = 8'hff;
  port_byte_t od_port_in, od_port_read, xmem_rdata, od_port_out, od_port_oe;
  port_byte_t input_port_read, analog_mode;
  logic [2:0] converter_chan_sel = 3'h0, analog_input_channel;
  logic       xmem_done, addr_phase, counter2_trigger_dir_input;
  int         mismatches = 0;
  int         checks_done = 0;

  always #50 core_clk = ~core_clk;

  port_pins uut (.core_clk(core_clk), .nrst(nrst), .od_latch_wr(od_latch_wr),
    .od_latch_wdata(od_latch_wdata), .od_port_read(od_port_read), .xmem_start(xmem_start),
    .xmem_write(xmem_write), .ext_addr_low(ext_addr_low), .xmem_wdata(xmem_wdata),
    .xmem_rdata(xmem_rdata), .xmem_done(xmem_done), .addr_phase(addr_phase),
    .od_port_in(od_port_in), .od_port_out(od_port_out), .od_port_oe(od_port_oe),
    .in_latch_wr(in_latch_wr), .in_latch_wdata(in_latch_wdata),
    .input_port_in(input_port_in), .input_port_read(input_port_read),
    .analog_mode(analog_mode), .converter_chan_sel(converter_chan_sel),
    .analog_input_channel(analog_input_channel),
    .counter2_trigger_dir_input(counter2_trigger_dir_input));

  ext_mem_model mem_u (.core_clk(core_clk), .addr_phase(addr_phase), .pin_out(od_port_out),
    .pin_oe(od_port_oe), .board_level(board_level), .pin_in(od_port_in));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic t_od_latch();
    od_latch_wdata = 8'h5a;
    od_latch_wr = 1'b1;
    cyc(1);
    od_latch_wr = 1'b0;
    chk(od_port_oe, 8'ha5);
    chk(od_port_out & od_port_oe, 8'h00);
    cyc(2);
    chk(od_port_read, 8'h5a);
  endtask

  task automatic t_xmem(input logic wr, input port_byte_t a, input port_byte_t d);
    xmem_write = wr;
    ext_addr_low = a;
    xmem_wdata = wr ? d : ~d;
    xmem_start = 1'b1;
    cyc(1);
    xmem_start = 1'b0;
    chk(od_port_out, a);
    chk(od_port_oe, 8'hff);
    chk({7'h0, addr_phase}, 8'h01);
    cyc(1);
    chk(od_port_oe, wr ? 8'hff : 8'h00);
    chk(wr ? od_port_out : {7'h0, addr_phase}, wr ? d : 8'h00);
    cyc(1);
    chk({7'h0, xmem_done}, 8'h01);
    chk(wr ? mem_u.mem[a] : xmem_rdata, d);
    chk(od_port_oe, 8'ha5);
  endtask

  task automatic t_input();
    input_port_in = 8'hff;
    cyc(3);
    chk(input_port_read, 8'h00);
    in_latch_wdata = 8'hfd;
    in_latch_wr = 1'b1;
    cyc(1);
    in_latch_wr = 1'b0;
    cyc(1);
    chk(analog_mode, 8'hfd);
    cyc(2);
    chk(input_port_read, 8'h02);
    chk({7'h0, counter2_trigger_dir_input}, 8'h01);
    input_port_in = 8'hfd;
    cyc(3);
    chk({7'h0, counter2_trigger_dir_input}, 8'h00);
  endtask

  task automatic t_chan();
    for (int i = 0; i < 8; i++) begin
      converter_chan_sel = 3'(i);
      cyc(2);
      chk({5'h0, analog_input_channel}, 8'(i));
    end
  endtask

  task automatic t_reset();
    od_latch_wdata = 8'h00;
    od_latch_wr = 1'b1;
    cyc(1);
    od_latch_wr = 1'b0;
    nrst = 1'b0;
    cyc(24);
    nrst = 1'b1;
    chk(od_port_oe, 8'h00);
    chk(analog_mode, 8'hff);
    cyc(2);
    chk(od_port_oe, 8'h00);
    chk(od_port_read, 8'hff);
    chk(input_port_read, 8'h00);
  endtask

  initial begin
    // short start-up reset
    cyc(4);
    nrst = 1'b1;
    chk(analog_mode, 8'hff);
    chk(od_port_oe, 8'h00);
    t_od_latch();
    t_xmem(1'b1, 8'h3c, 8'hc3);
    t_xmem(1'b0, 8'h3c, 8'hc3);
    t_input();
    t_chan();
    t_reset();
    finish_test();
  end

  initial begin
    #1000000;
    mismatches++;
    finish_test();
  end
endmodule
